// ### design/tcs_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "tcs_params.svh"

module tcs_top #(
   parameter int COUNT_W = `TCS_COUNT_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Register port
   input wire logic [`TCS_ADDR_W-1:0] reg_addr,
   input wire logic [`TCS_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [`TCS_DATA_W-1:0] reg_rdata,
   // Timer side
   input wire logic [COUNT_W-1:0] load_val,
   output logic [COUNT_W-1:0] count_val,
   output logic expire,
   // Interrupt
   output logic irq
);

   // Control, interrupt enable, status, read data and interrupt registers
   logic [`TCS_CTRL_W-1:0] ctrl_q;
   logic [`TCS_EV_W-1:0] ien_q;
   logic [`TCS_EV_W-1:0] stat_q;
   logic [`TCS_DATA_W-1:0] rdata_q;
   logic irq_q;

   // Address decode
   logic hit_count;
   logic hit_ctrl;
   logic hit_eoi;
   logic hit_stat;
   logic hit_ien;
   logic hit_any;
   logic bad_access;

   // Engine wires
   logic [COUNT_W-1:0] count_w;
   logic expire_w;
   tcs_pkg::tcs_mode_t mode_w;

   // Event sets and clears
   logic [`TCS_EV_W-1:0] ev_set;
   logic [`TCS_EV_W-1:0] ev_clr;

   assign hit_count = (reg_addr == `TCS_OFF_COUNT);
   assign hit_ctrl = (reg_addr == `TCS_OFF_CTRL);
   assign hit_eoi = (reg_addr == `TCS_OFF_EOI);
   assign hit_stat = (reg_addr == `TCS_OFF_STAT);
   assign hit_ien = (reg_addr == `TCS_OFF_IEN);
   assign hit_any = hit_count | hit_ctrl | hit_eoi | hit_stat | hit_ien;

   // Writes to read-only or unmapped words and reads of holes are flagged, never stall the master
   assign bad_access = (reg_wr & ~(hit_ctrl | hit_ien)) | (reg_rd & ~hit_any);

   // Control register: enable, mode, interrupt mask; reserved bits dropped
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ctrl_q <= `TCS_CTRL_RST;
      end else if (reg_wr && hit_ctrl) begin
         ctrl_q <= reg_wdata[`TCS_CTRL_W-1:0];
      end
   end

   // Interrupt enable register, same layout as status
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ien_q <= `TCS_IEN_RST;
      end else if (reg_wr && hit_ien) begin
         ien_q <= reg_wdata[`TCS_EV_W-1:0];
      end
   end

   // Mode field decoded into the engine's enumeration
   assign mode_w = ctrl_q[`TCS_CTRL_MODE] ? tcs_pkg::TCS_MODE_USER : tcs_pkg::TCS_MODE_FREE;

   // Counting engine
   tcs_counter #(
      .W(COUNT_W)
   ) u_counter (
      .clk(clk),
      .resetn(resetn),
      .enable(ctrl_q[`TCS_CTRL_EN]),
      .mode(mode_w),
      .load_val(load_val),
      .count_q(count_w),
      .expire_q(expire_w)
   );

   assign count_val = count_w;
   assign expire = expire_w;

   // Events: terminal count is the pending timer interrupt, bad access is a bus error
   always_comb begin
      ev_set = '0;
      ev_set[`TCS_EV_TC] = expire_w;
      ev_set[`TCS_EV_ERR] = bad_access;
   end

   // Status read clears every flag; clear-register read drops only the timer interrupt
   always_comb begin
      ev_clr = '0;
      if (reg_rd && hit_stat) begin
         ev_clr = '1;
      end
      if (reg_rd && hit_eoi) begin
         ev_clr[`TCS_EV_TC] = 1'b1;
      end
   end

   // Sticky status flags
   tcs_sticky #(
      .N(`TCS_EV_W)
   ) u_status (
      .clk(clk),
      .resetn(resetn),
      .set(ev_set),
      .clr(ev_clr),
      .flags_q(stat_q)
   );

   // Read data stands only in the cycle after the strobe, zero otherwise
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= '0;
         if (reg_rd) begin
            if (hit_count) begin
               rdata_q[COUNT_W-1:0] <= count_w;
            end else if (hit_ctrl) begin
               rdata_q[`TCS_CTRL_W-1:0] <= ctrl_q;
            end else if (hit_eoi) begin
               rdata_q <= `TCS_EOI_RDATA;
            end else if (hit_stat) begin
               rdata_q[`TCS_EV_W-1:0] <= stat_q;
            end else if (hit_ien) begin
               rdata_q[`TCS_EV_W-1:0] <= ien_q;
            end
         end
      end
   end

   assign reg_rdata = rdata_q;

   // Registered level: enabled pending flags, hidden while the control mask is set
   always_ff @(posedge clk) begin
      if (!resetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= (|(stat_q & ien_q)) & ~ctrl_q[`TCS_CTRL_MASK];
      end
   end

   assign irq = irq_q;

endmodule
`default_nettype wire

// ### design/tcs_params.svh
`ifndef TCS_PARAMS_SVH
`define TCS_PARAMS_SVH

// Register byte offsets
`define TCS_OFF_COUNT 8'h18
`define TCS_OFF_CTRL 8'h1C
`define TCS_OFF_EOI 8'h20
`define TCS_OFF_STAT 8'h24
`define TCS_OFF_IEN 8'h28

// Bus widths
`define TCS_ADDR_W 8
`define TCS_DATA_W 32

// Control field positions
`define TCS_CTRL_EN 0
`define TCS_CTRL_MODE 1
`define TCS_CTRL_MASK 2
`define TCS_CTRL_W 3

// Control reset value
`define TCS_CTRL_RST 3'h0

// Counter width and reset
`define TCS_COUNT_W 24
`define TCS_COUNT_RST 24'h000000

// Status / enable fields
`define TCS_EV_TC 0
`define TCS_EV_ERR 1
`define TCS_EV_W 2
`define TCS_STAT_RST 2'h0
`define TCS_IEN_RST 2'h3

// Read value of the clear register
`define TCS_EOI_RDATA 32'h0000_0000

`endif

// ### design/tcs_pkg.sv
package tcs_pkg;

   // Counting mode selected by the control register
   typedef enum logic {
      TCS_MODE_FREE,
      TCS_MODE_USER
   } tcs_mode_t;

   // Counting engine states
   typedef enum logic {
      TCS_ST_IDLE,
      TCS_ST_RUN
   } tcs_state_t;

endpackage

// ### design/tcs_counter.sv
`timescale 1ns/10ps
`default_nettype none
`include "tcs_params.svh"

module tcs_counter #(
   parameter int W = `TCS_COUNT_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Control
   input wire logic enable,
   input wire tcs_pkg::tcs_mode_t mode,
   input wire logic [W-1:0] load_val,
   // Results
   output logic [W-1:0] count_q,
   output logic expire_q
);

   tcs_pkg::tcs_state_t state_q;
   logic [W-1:0] reload;

   // Free-running counts the full range, user mode restarts from the load value
   assign reload = (mode == tcs_pkg::TCS_MODE_USER) ? load_val : {W{1'b1}};

   // State follows the enable bit; stopping holds the count
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_q <= tcs_pkg::TCS_ST_IDLE;
      end else begin
         unique case (state_q)
            tcs_pkg::TCS_ST_IDLE: begin
               if (enable) begin
                  state_q <= tcs_pkg::TCS_ST_RUN;
               end
            end
            tcs_pkg::TCS_ST_RUN: begin
               if (!enable) begin
                  state_q <= tcs_pkg::TCS_ST_IDLE;
               end
            end
         endcase
      end
   end

   // Down counter, reloads on start and after reaching zero
   always_ff @(posedge clk) begin
      if (!resetn) begin
         count_q <= `TCS_COUNT_RST;
      end else if (state_q == tcs_pkg::TCS_ST_IDLE) begin
         if (enable) begin
            count_q <= reload;
         end
      end else if (enable) begin
         if (count_q == '0) begin
            count_q <= reload;
         end else begin
            count_q <= count_q - 1'b1;
         end
      end
   end

   // One-cycle pulse at the terminal count
   always_ff @(posedge clk) begin
      if (!resetn) begin
         expire_q <= 1'b0;
      end else begin
         expire_q <= (state_q == tcs_pkg::TCS_ST_RUN) && enable && (count_q == '0);
      end
   end

endmodule
`default_nettype wire

// ### design/tcs_sticky.sv
`timescale 1ns/10ps
`default_nettype none

module tcs_sticky #(
   parameter int N = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Events and clears
   input wire logic [N-1:0] set,
   input wire logic [N-1:0] clr,
   // Held flags
   output logic [N-1:0] flags_q
);

   // Set wins over clear so an event in the clearing cycle is kept
   always_ff @(posedge clk) begin
      if (!resetn) begin
         flags_q <= '0;
      end else begin
         flags_q <= (flags_q & ~clr) | set;
      end
   end

endmodule
`default_nettype wire

// ### verif/tcs_props.sv
`timescale 1ns/10ps
`default_nettype none
`include "tcs_params.svh"

module tcs_props #(
   parameter int COUNT_W = `TCS_COUNT_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Register port
   input wire logic [`TCS_ADDR_W-1:0] reg_addr,
   input wire logic [`TCS_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [`TCS_DATA_W-1:0] reg_rdata,
   // Timer side
   input wire logic [COUNT_W-1:0] load_val,
   input wire logic [COUNT_W-1:0] count_val,
   input wire logic expire,
   input wire logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   logic [2:0] ctrl_q;

   // Shadow of the control bits, since the checker cannot see inside
   always_ff @(posedge clk) begin
      if (!resetn)
         ctrl_q <= 3'h0;
      else if (reg_wr && reg_addr == 8'h1C)
         ctrl_q <= reg_wdata[2:0];
   end

   a_count_read_back: assert property (
      reg_rd && reg_addr == 8'h18 |=> reg_rdata == {8'h00, $past(count_val)}) else $error("count read wrong");
   a_count_reset_zero: assert property (
      $rose(resetn) |-> count_val == 24'h000000) else $error("count not zero after reset");
   a_ctrl_read_back: assert property (
      reg_rd && reg_addr == 8'h1C |=> reg_rdata == {29'h0000000, $past(ctrl_q)}) else $error("control read wrong");
   a_stopped_count_holds: assert property (
      !ctrl_q[0] |=> $stable(count_val)) else $error("stopped count moved");
   a_mask_hides_irq: assert property (
      ctrl_q[2] && $past(ctrl_q[2]) |-> !irq) else $error("masked interrupt visible");
   a_clear_reads_zero: assert property (
      reg_rd && reg_addr == 8'h20 |=> reg_rdata == 32'h00000000) else $error("clear register not zero");
   a_clear_drops_pending: assert property (
      reg_rd && reg_addr == 8'h20 && !expire ##1 !expire ##1 reg_rd && reg_addr == 8'h24 |=> !reg_rdata[0])
      else $error("pending not cleared");
   a_expire_raises_irq: assert property (
      expire && !ctrl_q[2] && !reg_wr ##1 !reg_rd && !reg_wr |=> irq) else $error("interrupt missing");
endmodule

`default_nettype wire

// ### verif/tb_tcs_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_tcs_top;
   logic clk, resetn, reg_wr, reg_rd, expire, irq;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rv;
   logic [23:0] load_val, count_val, c0;
   int n_fail, n_compared, cyc;

   tcs_top DUT (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .load_val(load_val), .count_val(count_val), .expire(expire),
      .irq(irq));

   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Strobes change only at an edge; one idle edge after each so the next call never reassigns in that step
   task wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask

   // Read data stands between the two edges; taken at the second edge before it is cleared
   task rd(input logic [7:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      rv = reg_rdata;
   endtask

   task idle(input int n);
      repeat (n) @(posedge clk);
   endtask

   task t_reset;
      rd(8'h1C);
      chk("ctrl", rv, 32'h00000000);
      rd(8'h18);
      chk("count", rv, 32'h00000000);
      chk("irq", irq, 32'h00000000);
   endtask

   // Upper write bits must not stick
   task t_ctrl;
      for (int v = 0; v < 8; v++) begin
         wr(8'h1C, 32'hFFFFFFF8 | 32'(v));
         rd(8'h1C);
         chk("ctrl", rv, 32'(v));
      end
   endtask

   task t_count;
      load_val <= 24'h000003;
      wr(8'h1C, 32'h00000000);
      wr(8'h1C, 32'h00000003);
      for (int i = 0; i < 40 && expire !== 1'b1; i++) idle(1);
      chk("reload", count_val, 32'h00000003);
      idle(2);
      wr(8'h1C, 32'h00000002);
      c0 = count_val;
      idle(3);
      chk("held", count_val, c0);
      rd(8'h18);
      chk("count", rv, {8'h00, c0});
      wr(8'h1C, 32'h00000001);
      idle(4);
      chk("free", count_val[23:4], 32'h000FFFFF);
      wr(8'h1C, 32'h00000002);
   endtask

   task t_irq;
      idle(2);
      chk("irq", irq, 32'h00000001);
      wr(8'h1C, 32'h00000006);
      idle(2);
      chk("masked", irq, 32'h00000000);
      wr(8'h1C, 32'h00000002);
      idle(2);
      chk("unmasked", irq, 32'h00000001);
      rd(8'h20);
      chk("clear read", rv, 32'h00000000);
      rd(8'h24);
      idle(2);
      chk("cleared", irq, 32'h00000000);
   endtask

   task conclude;
      if (n_fail == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Hang guard, far beyond the fewer than a hundred cycles the run needs
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail++;
         conclude;
      end
   end

   initial begin
      resetn = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h00000000;
      load_val = 24'h000100;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      idle(1);
      t_reset;
      t_ctrl;
      t_count;
      t_irq;
      conclude;
   end
endmodule

bind tcs_top tcs_props #(.COUNT_W(COUNT_W)) u_props (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .load_val(load_val),
   .count_val(count_val), .expire(expire), .irq(irq));

`default_nettype wire
